// ---- pad_reset_pkg.sv ----
package pad_reset_pkg;
    localparam int PAD_COUNT = 46;
    localparam int GPIO_WIDTH = 8;
    localparam int PAD_STRAP_SWD = 8;
    localparam int PAD_PD_B = 9;
    localparam int PAD_SWD_CLK = 14;
    localparam int PAD_SWD_IO = 15;
    localparam int PAD_BOOT_OUT = 17;
    localparam int PAD_STRAP_DBG = 19;
    localparam int PAD_STRAP_BOOT = 20;
    localparam int PAD_ALT_SWD_IO = 44;
    localparam int PAD_ALT_SWD_CLK = 45;
    localparam int STRAP_SWD = 0;
    localparam int STRAP_DBG = 1;
    localparam int STRAP_BOOT = 2;
    localparam logic [2:0] STRAP_RESET = 3'h0;
    localparam logic [45:0] RST_PULL_UP = 46'h0000_0000_C003;
    localparam logic [45:0] RST_PULL_DOWN = 46'h0000_0018_0300;
    localparam logic [45:0] RST_OUT_EN_N = 46'h3FFF_FFFF_FFFF;
    localparam logic [45:0] RST_OUT = 46'h0000_0000_0000;
    // first and second candidate pad of each gpio bit, bit 0 rightmost
    localparam logic [7:0][5:0] GPIO_PAD_A = {6'h17, 6'h16, 6'h15, 6'h12,
        6'h0E, 6'h0B, 6'h09, 6'h06};
    localparam logic [7:0][5:0] GPIO_PAD_B = {6'h2D, 6'h26, 6'h24, 6'h1F,
        6'h1E, 6'h1C, 6'h1A, 6'h18};
    typedef enum logic [1:0] {
        PHASE_HELD = 2'h0,
        PHASE_SAMPLE = 2'h1,
        PHASE_RUN = 2'h3
    } phase_t;
endpackage

// ---- gpio_pad_select.sv ----
`timescale 1ns/100ps
`default_nettype none
module gpio_pad_select (
    input wire logic enable, // gpio bit routed to a pad
    input wire logic padSel, // 0 first candidate, 1 second
    input wire logic padAIn, // synchronised level of first pad
    input wire logic padBIn, // synchronised level of second pad
    output logic useA, // first pad carries the bit
    output logic useB, // second pad carries the bit
    output logic selIn // level seen on the chosen pad
);
    // one select bit can only ever name one pad
    assign useA = enable & ~padSel;
    assign useB = enable & padSel;
    assign selIn = enable & (padSel ? padBIn : padAIn);
endmodule
`default_nettype wire

// ---- pad_reset_state_control.sv ----
// Overview of operation
// - Pads 0 and 1 are weakly pulled up in and after system reset.
// - Pads 8 and 9 are weakly pulled down in and after system reset.
// - Pads 14, 15 pull up in reset; after it Z if straps 19 and 8 are high, unless gpio bit 3 drives pad 14.
// - Pad 17 is low in reset while pad 20 is low, else Z; Z after release.
// - Pads 19 and 20 are weakly pulled down in and after system reset.
// - Pads 44 and 45 are Z in reset and after it follow strap 8, unless gpio bit 7 drives pad 45.
// - All other pads stay Z in reset; after it they stay Z unless a gpio bit drives them.
// - Eight gpio bits each route to one of a fixed pair of pads.
// - Each gpio bit connects to at most one of its candidate pads at a time.
// - Bit 0 uses pad 6 or 24, bit 1 pad 9 or 26, others fixed pairs.
// - Pad 19 is a strap selecting debugger mode to release the core.
`timescale 1ns/100ps
`default_nettype none
module pad_reset_state_control (
    input wire logic core_clk, // 25 MHz core clock
    input wire logic reset, // synchronous, active high
    input wire logic system_reset_low_pin, // system reset pin, low asserts
    input wire logic [45:0] padIn, // pad input levels
    input wire logic [7:0] gpioEnable, // route gpio bit to a pad
    input wire logic [7:0] gpioPadSel, // candidate pad per bit
    input wire logic [7:0] gpioDir, // 1 drives the pad
    input wire logic [7:0] gpioOut, // value driven
    output logic [45:0] padPullUp, // weak pull-up enable
    output logic [45:0] padPullDown, // weak pull-down enable
    output logic [45:0] padOut, // pad output value
    output logic [45:0] padOutEnN, // low while the pad is driven
    output logic [7:0] gpioIn, // level of each routed pad
    output logic debugBoot // debugger boot strap caught
);
    logic [45:0] padMeta_reg, padSync_reg;
    logic rstPinMeta_reg, rstPinSync_reg;
    pad_reset_pkg::phase_t phase_reg, phase_next;
    logic [2:0] strap_reg, strap_next;
    logic [45:0] pullUp_reg, pullUp_next, pullDown_reg, pullDown_next;
    logic [45:0] out_reg, out_next, outEnN_reg, outEnN_next;
    logic [7:0] gpioIn_reg, gpioIn_next;
    logic [7:0] useA, useB, selIn;
    logic held;
    logic [7:0] bothDriven;

    always_ff @(posedge core_clk) begin
        padMeta_reg <= padIn;
        padSync_reg <= padMeta_reg;
        rstPinMeta_reg <= system_reset_low_pin;
        rstPinSync_reg <= rstPinMeta_reg;
    end

    genvar g;
    generate
        for (g = 0; g < pad_reset_pkg::GPIO_WIDTH; g++) begin : gBit
            gpio_pad_select i_gpio_pad_select (
                .enable(gpioEnable[g]),
                .padSel(gpioPadSel[g]),
                .padAIn(padSync_reg[pad_reset_pkg::GPIO_PAD_A[g]]),
                .padBIn(padSync_reg[pad_reset_pkg::GPIO_PAD_B[g]]),
                .useA(useA[g]),
                .useB(useB[g]),
                .selIn(selIn[g])
            );
        end
    endgenerate

    always_comb begin
        phase_next = phase_reg;
        strap_next = strap_reg;
        case (phase_reg)
            pad_reset_pkg::PHASE_HELD: begin
                if (rstPinSync_reg) begin
                    phase_next = pad_reset_pkg::PHASE_SAMPLE;
                end
            end
            pad_reset_pkg::PHASE_SAMPLE: begin
                // straps caught once at release, then frozen
                strap_next[pad_reset_pkg::STRAP_SWD] =
                    padSync_reg[pad_reset_pkg::PAD_STRAP_SWD];
                strap_next[pad_reset_pkg::STRAP_DBG] =
                    padSync_reg[pad_reset_pkg::PAD_STRAP_DBG];
                strap_next[pad_reset_pkg::STRAP_BOOT] =
                    padSync_reg[pad_reset_pkg::PAD_STRAP_BOOT];
                phase_next = rstPinSync_reg ? pad_reset_pkg::PHASE_RUN
                                            : pad_reset_pkg::PHASE_HELD;
            end
            pad_reset_pkg::PHASE_RUN: begin
                if (!rstPinSync_reg) begin
                    phase_next = pad_reset_pkg::PHASE_HELD;
                end
            end
            default: phase_next = pad_reset_pkg::PHASE_HELD;
        endcase
    end

    always_comb begin
        held = (phase_reg != pad_reset_pkg::PHASE_RUN);
        pullUp_next = pad_reset_pkg::RST_PULL_UP;
        pullDown_next = pad_reset_pkg::RST_PULL_DOWN;
        outEnN_next = pad_reset_pkg::RST_OUT_EN_N;
        out_next = pad_reset_pkg::RST_OUT;
        gpioIn_next = held ? 8'h00 : selIn;
        if (held) begin
            outEnN_next[pad_reset_pkg::PAD_BOOT_OUT] =
                padSync_reg[pad_reset_pkg::PAD_STRAP_BOOT];
        end else begin
            if (strap_reg[pad_reset_pkg::STRAP_DBG] &&
                    strap_reg[pad_reset_pkg::STRAP_SWD]) begin
                pullUp_next[pad_reset_pkg::PAD_SWD_CLK] = 1'b0;
                pullUp_next[pad_reset_pkg::PAD_SWD_IO] = 1'b0;
            end
            // debug port moves to the alternate pair when strap 8 is high
            pullUp_next[pad_reset_pkg::PAD_ALT_SWD_IO] =
                strap_reg[pad_reset_pkg::STRAP_SWD];
            pullUp_next[pad_reset_pkg::PAD_ALT_SWD_CLK] =
                strap_reg[pad_reset_pkg::STRAP_SWD];
            for (int b = 0; b < pad_reset_pkg::GPIO_WIDTH; b++) begin
                if (useA[b]) begin
                    outEnN_next[pad_reset_pkg::GPIO_PAD_A[b]] = ~gpioDir[b];
                    out_next[pad_reset_pkg::GPIO_PAD_A[b]] =
                        gpioDir[b] & gpioOut[b];
                end
                if (useB[b]) begin
                    outEnN_next[pad_reset_pkg::GPIO_PAD_B[b]] = ~gpioDir[b];
                    out_next[pad_reset_pkg::GPIO_PAD_B[b]] =
                        gpioDir[b] & gpioOut[b];
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            phase_reg <= pad_reset_pkg::PHASE_HELD;
            strap_reg <= pad_reset_pkg::STRAP_RESET;
            pullUp_reg <= pad_reset_pkg::RST_PULL_UP;
            pullDown_reg <= pad_reset_pkg::RST_PULL_DOWN;
            outEnN_reg <= pad_reset_pkg::RST_OUT_EN_N;
            out_reg <= pad_reset_pkg::RST_OUT;
            gpioIn_reg <= 8'h00;
        end else begin
            phase_reg <= phase_next;
            strap_reg <= strap_next;
            pullUp_reg <= pullUp_next;
            pullDown_reg <= pullDown_next;
            outEnN_reg <= outEnN_next;
            out_reg <= out_next;
            gpioIn_reg <= gpioIn_next;
        end
    end

    assign padPullUp = pullUp_reg;
    assign padPullDown = pullDown_reg;
    assign padOut = out_reg;
    assign padOutEnN = outEnN_reg;
    assign gpioIn = gpioIn_reg;
    assign debugBoot = strap_reg[pad_reset_pkg::STRAP_DBG];

    // seen at the pads: no gpio bit may drive both of its candidates
    always_comb begin
        bothDriven = 8'h00;
        for (int b = 0; b < pad_reset_pkg::GPIO_WIDTH; b++) begin
            bothDriven[b] = !padOutEnN[pad_reset_pkg::GPIO_PAD_A[b]] &&
                !padOutEnN[pad_reset_pkg::GPIO_PAD_B[b]];
        end
    end

    a_pad01_pullup: assert property (@(posedge core_clk)
        disable iff (reset)
        padPullUp[0] && padPullUp[1] && !padPullDown[0] && !padPullDown[1])
        else $error("pads 0 or 1 lost pull-up");
    a_strap_pulldown: assert property (@(posedge core_clk)
        disable iff (reset)
        padPullDown[19] && padPullDown[20] && padPullDown[8] &&
            padPullDown[9])
        else $error("strap pad lost pull-down");
    a_pad17_boot_low: assert property (@(posedge core_clk)
        disable iff (reset)
        (phase_reg == pad_reset_pkg::PHASE_HELD && !padSync_reg[20])
        |=> (!padOutEnN[17] && !padOut[17]))
        else $error("pad 17 not driven low in reset");
    a_pad17_boot_z: assert property (@(posedge core_clk)
        disable iff (reset)
        (phase_reg == pad_reset_pkg::PHASE_HELD && padSync_reg[20])
        |=> padOutEnN[17])
        else $error("pad 17 driven in reset with pad 20 high");
    a_pad17_run_z: assert property (@(posedge core_clk)
        disable iff (reset)
        (phase_reg == pad_reset_pkg::PHASE_RUN) |=> padOutEnN[17])
        else $error("pad 17 driven after release");
    a_strap_held: assert property (@(posedge core_clk)
        disable iff (reset)
        (phase_reg == pad_reset_pkg::PHASE_RUN)
        ##1 (phase_reg == pad_reset_pkg::PHASE_RUN) |-> $stable(strap_reg))
        else $error("strap changed while running");
    a_strap_catch: assert property (@(posedge core_clk)
        disable iff (reset)
        (phase_reg == pad_reset_pkg::PHASE_SAMPLE)
        |=> (strap_reg[0] == $past(padSync_reg[8]) &&
            strap_reg[1] == $past(padSync_reg[19]) &&
            strap_reg[2] == $past(padSync_reg[20])))
        else $error("straps not caught at release");
    a_pad44_strap: assert property (@(posedge core_clk)
        disable iff (reset)
        (phase_reg == pad_reset_pkg::PHASE_RUN)
        |=> (padPullUp[44] == $past(strap_reg[0]) && padOutEnN[44]))
        else $error("pad 44 state not from strap 8");
    a_pad45_strap: assert property (@(posedge core_clk)
        disable iff (reset)
        (phase_reg == pad_reset_pkg::PHASE_RUN)
        |=> (padPullUp[45] == $past(strap_reg[0]) &&
            !padPullDown[44] && !padPullDown[45]))
        else $error("pad 45 state not from strap 8");
    a_pad14_release_z: assert property (@(posedge core_clk)
        disable iff (reset)
        (phase_reg == pad_reset_pkg::PHASE_RUN && strap_reg[1] &&
            strap_reg[0])
        |=> !padPullUp[14] && !padPullUp[15])
        else $error("pads 14 15 still pulled up");
    a_pad14_keep_pu: assert property (@(posedge core_clk)
        disable iff (reset)
        (phase_reg == pad_reset_pkg::PHASE_RUN &&
            !(strap_reg[1] && strap_reg[0]))
        |=> padPullUp[14] && padPullUp[15])
        else $error("pads 14 15 lost pull-up");
    a_gpio_one_pad: assert property (@(posedge core_clk)
        disable iff (reset)
        (useA & useB) == 8'h00 && bothDriven == 8'h00)
        else $error("gpio bit on two pads");
    a_gpio0_drive: assert property (@(posedge core_clk)
        disable iff (reset)
        (phase_reg == pad_reset_pkg::PHASE_RUN && gpioEnable[0] &&
            !gpioPadSel[0] && gpioDir[0])
        |=> (!padOutEnN[6] && padOut[6] == $past(gpioOut[0]) &&
            padOutEnN[24]))
        else $error("gpio bit 0 not on pad 6");
    a_gpio0_pad24: assert property (@(posedge core_clk)
        disable iff (reset)
        (phase_reg == pad_reset_pkg::PHASE_RUN && gpioEnable[0] &&
            gpioPadSel[0] && gpioDir[0])
        |=> (!padOutEnN[24] && padOut[24] == $past(gpioOut[0]) &&
            padOutEnN[6]))
        else $error("gpio bit 0 not on pad 24");
    a_gpio_in_held: assert property (@(posedge core_clk)
        disable iff (reset)
        (phase_reg != pad_reset_pkg::PHASE_RUN) |=> gpioIn == 8'h00)
        else $error("gpio input seen while held");
    a_pad2_z: assert property (@(posedge core_clk)
        disable iff (reset)
        padOutEnN[2] && !padPullUp[2] && !padPullDown[2])
        else $error("pad 2 not high impedance");
    a_pad16_z: assert property (@(posedge core_clk)
        disable iff (reset)
        padOutEnN[16] && !padPullUp[16] && !padPullDown[16])
        else $error("pad 16 not high impedance");
endmodule
`default_nettype wire

// ---- board_strap_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module board_strap_model (
    input wire logic [45:0] padOutEnN, // low where the device drives
    input wire logic [45:0] padOut, // device drive value
    input wire logic [45:0] extLevel, // straps and attached circuits
    output logic [45:0] padIn // level seen on each pad
);
    // board parts overpower the weak pulls; a driven pad shows the device
    // straps 8, 19 and 20 are plain bits of extLevel
    assign padIn = (~padOutEnN & padOut) | (padOutEnN & extLevel);
endmodule
`default_nettype wire

// ---- pad_reset_state_control_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module pad_reset_state_control_bench;
    typedef struct {
        logic [45:0] pu, pd, oen, out;
        logic [7:0] gin;
        logic dbg, chkDbg;
    } exp_t;
    logic core_clk = 1'b0, reset = 1'b1, sysRstN = 1'b0, chk = 1'b0;
    logic [45:0] ext = '0, padIn, pu, pd, pOut, oen;
    logic [7:0] gEn = '0, gSel = '0, gDir = '0, gOut = '0, gIn;
    logic dbg;
    int error_cnt = 0, n_tests = 0, seed = 2, cycles = 0;
    int padA[8] = '{6, 9, 11, 14, 18, 21, 22, 23};
    int padB[8] = '{24, 26, 28, 30, 31, 36, 38, 45};
    exp_t expQ[$];
    exp_t e;
    logic [45:0] x;
    always #20 core_clk = ~core_clk;
    pad_reset_state_control i_pad_reset_state_control (.core_clk(core_clk),
        .reset(reset), .system_reset_low_pin(sysRstN), .padIn(padIn),
        .gpioEnable(gEn), .gpioPadSel(gSel), .gpioDir(gDir),
        .gpioOut(gOut), .padPullUp(pu), .padPullDown(pd), .padOut(pOut),
        .padOutEnN(oen), .gpioIn(gIn), .debugBoot(dbg));
    board_strap_model i_board_strap_model (.padOutEnN(oen), .padOut(pOut),
        .extLevel(ext), .padIn(padIn));
    function automatic exp_t expOf(bit run, logic [45:0] xl,
        logic [2:0] st);
        exp_t r;
        int p;
        r.pu = '0;
        r.pd = '0;
        r.pu[1:0] = 2'h3;
        r.pu[15:14] = 2'h3;
        r.pd[9:8] = 2'h3;
        r.pd[20:19] = 2'h3;
        r.oen = '1;
        r.out = '0;
        r.gin = '0;
        r.dbg = st[1];
        r.chkDbg = run;
        if (!run) begin
            r.oen[17] = xl[20];
        end else begin
            r.pu[45:44] = {2{st[0]}};
            if (st[1] & st[0]) r.pu[15:14] = 2'h0;
            for (int b = 0; b < 8; b++) begin
                p = gSel[b] ? padB[b] : padA[b];
                if (gEn[b] && gDir[b]) begin
                    r.oen[p] = 1'b0;
                    r.out[p] = gOut[b];
                end
                if (gEn[b]) r.gin[b] = gDir[b] ? gOut[b] : xl[p];
            end
        end
        return r;
    endfunction
    task automatic cmp(string nm, logic [45:0] ex, logic [45:0] sn);
        n_tests++;
        if (ex !== sn) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, sn);
            error_cnt++;
        end
    endtask
    task automatic apply(bit run, logic [2:0] st, logic [45:0] xl);
        @(posedge core_clk);
        ext <= xl;
        gEn <= 8'($random(seed));
        gSel <= 8'($random(seed));
        gDir <= 8'($random(seed));
        gOut <= 8'($random(seed));
        repeat (6) @(posedge core_clk);
        expQ.push_back(expOf(run, xl, st));
        chk <= 1'b1;
        @(posedge core_clk);
        chk <= 1'b0;
    endtask
    task final_report;
        if (error_cnt == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge core_clk) begin
        if (chk) begin
            e = expQ.pop_front();
            cmp("padPullUp", e.pu, pu);
            cmp("padPullDown", e.pd, pd);
            cmp("padOutEnN", e.oen, oen);
            cmp("padOut", e.out, pOut);
            cmp("gpioIn", {38'h0, e.gin}, {38'h0, gIn});
            if (e.chkDbg) begin
                cmp("debugBoot", {45'h0, e.dbg}, {45'h0, dbg});
            end
        end
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 1000) begin
            error_cnt++;
            final_report;
        end
    end
    initial begin
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        for (int s = 0; s < 8; s++) begin
            x = 46'({$random(seed), $random(seed)});
            x[8] = s[0];
            x[19] = s[1];
            x[20] = s[2];
            @(posedge core_clk);
            sysRstN <= 1'b0;
            apply(1'b0, 3'h0, x);
            @(posedge core_clk);
            sysRstN <= 1'b1;
            repeat (8) @(posedge core_clk);
            // straps must hold while the pads change afterwards
            repeat (3) begin
                x = 46'({$random(seed), $random(seed)});
                apply(1'b1, s[2:0], x);
            end
        end
        repeat (2) @(posedge core_clk);
        final_report;
    end
endmodule
`default_nettype wire
